// file: rftd_readout.sv
// Tag detection, debounce, object access and event-driven readout
`timescale 1ns/1ps
module rftd_readout #(
    parameter int          N_ENTRIES      = 64,
    parameter int          POLL_CYCLES    = rftd_pkg::POLL_CYCLES,
    parameter logic [5:0]  USER_BLK_BYTES = 6'h04,
    parameter logic [11:0] USER_BLK_COUNT = 12'h001
) (
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    // Object access port from the network stack
    input  wire logic                  od_valid_i,
    input  wire rftd_pkg::rftd_od_req_s od_req_i,
    output logic                       od_ack_o,
    output logic                       od_err_o,
    output logic [63:0]                od_rdata_o,
    // Message mapping held by the network stack
    input  wire logic                  uid_mapped_i,
    input  wire logic [N_ENTRIES-1:0]  data_mapped_i,
    // Parameter save and restore
    input  wire logic                  save_req_i,
    input  wire logic                  nv_load_i,
    input  wire logic [7:0]            nv_type_i,
    output logic                       nv_save_o,
    output logic [7:0]                 nv_type_o,
    // RF front end
    output logic                       field_en_o,
    output logic                       poll_o,
    input  wire logic                  fe_done_i,
    input  wire rftd_pkg::rftd_fe_res_s fe_res_i,
    output logic [5:0]                 blk_bytes_o,
    output logic [11:0]                blk_count_o,
    output logic                       tag_present_o,
    // Tag memory read
    output logic                       rd_req_valid_o,
    input  wire logic                  rd_req_ready_i,
    output logic [15:0]                rd_addr_o,
    output logic [3:0]                 rd_len_o,
    input  wire logic                  rd_done_i,
    input  wire logic [63:0]           rd_data_i,
    // Transmit messages
    output logic                       pdo_valid_o,
    input  wire logic                  pdo_ready_i,
    output rftd_pkg::rftd_pdo_s        pdo_o
);

    localparam int IW = $clog2(N_ENTRIES);

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_UID  = 6'b000010,
        S_SCAN = 6'b000100,
        S_REQ  = 6'b001000,
        S_WAIT = 6'b010000,
        S_PUSH = 6'b100000
    } rftd_fsm_e;

    typedef struct packed {
        logic [7:0]                  antenna;
        logic [7:0]                  type_sel;
        logic [7:0]                  on_depth;
        logic [7:0]                  off_depth;
        logic [N_ENTRIES-1:0][15:0]  rd_start;
        logic [N_ENTRIES-1:0][7:0]   rd_len;
        logic [N_ENTRIES-1:0][63:0]  rd_data;
        logic                        present;
        logic                        reported;
        logic                        last_raw;
        logic [8:0]                  run_cnt;
        logic [63:0]                 uid;
        logic [7:0]                  det_type;
        logic [3:0]                  strength;
        logic [23:0]                 poll_cnt;
        logic                        poll;
        rftd_fsm_e                   fsm;
        logic [IW:0]                 scan;
        rftd_pkg::rftd_pdo_s [1:0]   buf_q;
        logic [1:0]                  buf_cnt;
        logic                        buf_head;
        logic [63:0]                 od_rdata;
        logic                        od_ack;
        logic                        od_err;
        logic                        nv_save;
    } rftd_state_s;

    rftd_state_s st;
    rftd_state_s next_st;
    logic        rst_meta;
    logic        rst_sync_n;

    //////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Keep only the configured bytes, upper bytes read zero
    function automatic logic [63:0] keep_bytes(input logic [63:0] d,
                                               input logic [3:0]  n);
        logic [63:0] r;
        r = '0;
        for (int b = 0; b < 8; b++) begin
            if (4'(b) < n) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Clamp a length to the wide object size
    function automatic logic [3:0] clamp_len(input logic [7:0] len);
        return (len > 8'(rftd_pkg::WIDE_BYTES)) ? rftd_pkg::WIDE_BYTES
                                                : len[3:0];
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Combinational next state
    logic              raw;
    logic [8:0]        cnt_new;
    logic              push;
    rftd_pkg::rftd_pdo_s push_d;
    logic              room;
    logic [IW-1:0]     idx;
    logic [IW:0]       sub_idx;
    logic              sub_ok;
    logic [63:0]       rdat;
    logic              rerr;

    always_comb begin
        next_st = st;
        raw     = 1'b0;
        cnt_new = '0;
        push    = 1'b0;
        push_d  = '0;
        room    = (st.buf_cnt != 2'd2);
        idx     = st.scan[IW-1:0];
        sub_idx = (IW+1)'(od_req_i.sub) - (IW+1)'(1);
        sub_ok  = (od_req_i.sub >= rftd_pkg::SUB_FIRST) &&
                  ({1'b0, od_req_i.sub} <= 9'(N_ENTRIES));
        rdat    = '0;
        rerr    = 1'b0;
        next_st.od_ack  = 1'b0;
        next_st.od_err  = 1'b0;
        next_st.nv_save = 1'b0;
        next_st.poll    = 1'b0;

        // Poll tick only while the field is on
        if (st.antenna != rftd_pkg::ANT_OFF) begin
            if (st.poll_cnt >= 24'(POLL_CYCLES - 1)) begin
                next_st.poll_cnt = '0;
                next_st.poll     = 1'b1;
            end else begin
                next_st.poll_cnt = st.poll_cnt + 24'd1;
            end
        end else begin
            next_st.poll_cnt = '0;
        end

        // Debounce: count runs of equal results, restart on a flip
        if (fe_done_i && st.antenna != rftd_pkg::ANT_OFF) begin
            raw = fe_res_i.found;
            if (raw != st.last_raw) begin
                cnt_new = 9'd1;
            end else if (st.run_cnt != 9'h1ff) begin
                cnt_new = st.run_cnt + 9'd1;
            end else begin
                cnt_new = st.run_cnt;
            end
            next_st.last_raw = raw;
            next_st.run_cnt  = cnt_new;
            // Depth N asserts on success N+1; zero means at once
            if (raw && !st.present &&
                cnt_new > {1'b0, st.on_depth}) begin
                next_st.present  = 1'b1;
                next_st.uid      = fe_res_i.uid;
                next_st.det_type = fe_res_i.tag_type;
            end
            if (!raw && st.present &&
                cnt_new > {1'b0, st.off_depth}) begin
                next_st.present = 1'b0;
            end
            if (raw) begin
                next_st.strength = (fe_res_i.strength > rftd_pkg::STRENGTH_MAX)
                                 ? rftd_pkg::STRENGTH_MAX
                                 : ((fe_res_i.strength == 4'h0) ? 4'h1
                                                 : fe_res_i.strength);
            end
        end

        // Field off: nothing is in front of the head
        if (st.antenna == rftd_pkg::ANT_OFF) begin
            next_st.present  = 1'b0;
            next_st.last_raw = 1'b0;
            next_st.run_cnt  = '0;
        end

        // Info objects only hold values while a tag is present
        if (!next_st.present) begin
            next_st.uid      = '0;
            next_st.det_type = '0;
            next_st.strength = '0;
        end

        // Readout sequencer
        unique case (st.fsm)
            S_IDLE: begin
                if (st.present != st.reported) begin
                    next_st.reported = st.present;
                    next_st.scan     = '0;
                    next_st.fsm      = S_UID;
                end
            end
            S_UID: begin
                // Arrival announces the UID; departure sends the UID message with zero data
                if (!uid_mapped_i || room) begin
                    push   = uid_mapped_i;
                    push_d = '{1'b1, rftd_pkg::SUB_LIST_UID, st.uid};
                    next_st.fsm = st.reported ? S_SCAN : S_IDLE;
                end
            end
            S_SCAN: begin
                if (!st.present || st.scan == (IW+1)'(N_ENTRIES)) begin
                    next_st.fsm = S_IDLE;
                end else if (data_mapped_i[idx]) begin
                    next_st.fsm = S_REQ;
                end else begin
                    next_st.scan = st.scan + (IW+1)'(1);
                end
            end
            S_REQ: begin
                if (rd_req_ready_i) begin
                    next_st.fsm = S_WAIT;
                end
            end
            S_WAIT: begin
                if (rd_done_i) begin
                    next_st.rd_data[idx] = keep_bytes(rd_data_i,
                        clamp_len(st.rd_len[idx]));
                    next_st.fsm = S_PUSH;
                end
            end
            S_PUSH: begin
                // Stall here while the buffer is full
                if (room) begin
                    push   = 1'b1;
                    push_d = '{1'b0, 8'(idx) + 8'h01, st.rd_data[idx]};
                    next_st.scan = st.scan + (IW+1)'(1);
                    next_st.fsm  = S_SCAN;
                end
            end
            default: next_st.fsm = S_IDLE;
        endcase

        // Two-entry message buffer; pop and push may share a cycle
        if (pdo_ready_i && st.buf_cnt != 2'd0) begin
            next_st.buf_head = ~st.buf_head;
            next_st.buf_cnt  = st.buf_cnt - 2'd1;
        end
        if (push) begin
            next_st.buf_q[st.buf_head ^ st.buf_cnt[0]] = push_d;
            next_st.buf_cnt = next_st.buf_cnt + 2'd1;
        end

        // Object access: one request, answered one cycle later
        if (od_valid_i) begin
            next_st.od_ack = 1'b1;
            if (od_req_i.wr) begin
                unique case (od_req_i.index)
                    rftd_pkg::OBJ_ANTENNA: begin
                        if (od_req_i.wdata[7:0] == rftd_pkg::ANT_OFF ||
                            od_req_i.wdata[7:0] == rftd_pkg::ANT_ON) begin
                            next_st.antenna = od_req_i.wdata[7:0];
                        end else begin
                            rerr = 1'b1;
                        end
                    end
                    rftd_pkg::OBJ_TYPE_SEL: begin
                        if (od_req_i.wdata[7:0] >= rftd_pkg::TYPE_USER &&
                            od_req_i.wdata[7:0] <= rftd_pkg::TYPE_LAST) begin
                            next_st.type_sel = od_req_i.wdata[7:0];
                        end else begin
                            rerr = 1'b1;
                        end
                    end
                    rftd_pkg::OBJ_ON_DEPTH:
                        next_st.on_depth = od_req_i.wdata[7:0];
                    rftd_pkg::OBJ_OFF_DEPTH:
                        next_st.off_depth = od_req_i.wdata[7:0];
                    rftd_pkg::OBJ_RD_START: begin
                        if (sub_ok) begin
                            next_st.rd_start[sub_idx[IW-1:0]] =
                                od_req_i.wdata[15:0];
                        end else begin
                            rerr = 1'b1;
                        end
                    end
                    rftd_pkg::OBJ_RD_LEN: begin
                        if (sub_ok) begin
                            next_st.rd_len[sub_idx[IW-1:0]] =
                                od_req_i.wdata[7:0];
                        end else begin
                            rerr = 1'b1;
                        end
                    end
                    default: rerr = 1'b1;
                endcase
            end else begin
                unique case (od_req_i.index)
                    rftd_pkg::OBJ_ANTENNA:   rdat = 64'(st.antenna);
                    rftd_pkg::OBJ_TYPE_SEL:  rdat = 64'(st.type_sel);
                    rftd_pkg::OBJ_STRENGTH:  rdat = 64'(st.strength);
                    rftd_pkg::OBJ_ON_DEPTH:  rdat = 64'(st.on_depth);
                    rftd_pkg::OBJ_OFF_DEPTH: rdat = 64'(st.off_depth);
                    rftd_pkg::OBJ_INFO_LIST: begin
                        // Sub 1 the UID, subs 2..14 the type codes
                        if (od_req_i.sub == rftd_pkg::SUB_LIST_UID) begin
                            rdat = st.uid;
                        end else if (od_req_i.sub > rftd_pkg::SUB_LIST_UID &&
                                     od_req_i.sub <= rftd_pkg::TYPE_LAST +
                                     8'h01) begin
                            rdat = st.present ? 64'(od_req_i.sub - 8'h01)
                                              : '0;
                        end else if (od_req_i.sub > rftd_pkg::SUB_INFO_LAST ||
                                     od_req_i.sub == 8'h00) begin
                            rerr = 1'b1;
                        end
                    end
                    rftd_pkg::OBJ_INFO_DETAIL: begin
                        if (od_req_i.sub == rftd_pkg::SUB_DETECTED_TYPE) begin
                            rdat = 64'(st.det_type);
                        end
                    end
                    rftd_pkg::OBJ_UID_A: rdat = 64'(st.uid[31:0]);
                    rftd_pkg::OBJ_UID_B: rdat = 64'(st.uid[63:32]);
                    rftd_pkg::OBJ_RD_START: begin
                        rerr = !sub_ok;
                        rdat = 64'(st.rd_start[sub_idx[IW-1:0]]);
                    end
                    rftd_pkg::OBJ_RD_LEN: begin
                        rerr = !sub_ok;
                        rdat = 64'(st.rd_len[sub_idx[IW-1:0]]);
                    end
                    rftd_pkg::OBJ_RD_WIDE: begin
                        rerr = !sub_ok;
                        rdat = st.rd_data[sub_idx[IW-1:0]];
                    end
                    rftd_pkg::OBJ_RD_NARROW: begin
                        // Stored data is already cut to its length
                        rerr = !sub_ok;
                        rdat = keep_bytes(st.rd_data[sub_idx[IW-1:0]],
                                          rftd_pkg::NARROW_BYTES);
                    end
                    default: rerr = 1'b1;
                endcase
            end
            next_st.od_err   = rerr;
            next_st.od_rdata = rerr ? '0 : rdat;
        end

        // Restore wins over a same-cycle object write
        if (nv_load_i && nv_type_i >= rftd_pkg::TYPE_USER &&
            nv_type_i <= rftd_pkg::TYPE_LAST) begin
            next_st.type_sel = nv_type_i;
        end
        if (save_req_i) begin
            next_st.nv_save = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st           <= '0;
            st.antenna   <= rftd_pkg::RST_ANTENNA;
            st.type_sel  <= rftd_pkg::RST_TYPE_SEL;
            st.on_depth  <= rftd_pkg::RST_DEPTH;
            st.off_depth <= rftd_pkg::RST_DEPTH;
            st.fsm       <= S_IDLE;
        end else begin
            st <= next_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    rftd_pkg::rftd_geom_s geom;

    always_comb begin
        geom = rftd_pkg::rftd_geom(st.type_sel);
        if (st.type_sel == rftd_pkg::TYPE_USER) begin
            geom = '{USER_BLK_BYTES, USER_BLK_COUNT};
        end
    end

    assign blk_bytes_o    = geom.blk_bytes;
    assign blk_count_o    = geom.blk_count;
    assign field_en_o     = (st.antenna != rftd_pkg::ANT_OFF);
    assign poll_o         = st.poll;
    assign tag_present_o  = st.present;
    assign od_ack_o       = st.od_ack;
    assign od_err_o       = st.od_err;
    assign od_rdata_o     = st.od_rdata;
    assign nv_save_o      = st.nv_save;
    assign nv_type_o      = st.type_sel;
    assign rd_req_valid_o = (st.fsm == S_REQ);
    assign rd_addr_o      = st.rd_start[st.scan[IW-1:0]];
    assign rd_len_o       = clamp_len(st.rd_len[st.scan[IW-1:0]]);
    assign pdo_valid_o    = (st.buf_cnt != 2'd0);
    assign pdo_o          = st.buf_q[st.buf_head];

endmodule

// file: rftd_pkg.sv
// Shared constants, object map and carriers for the tag detect readout
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Antenna object written zero switches field off
// - Antenna object written one resumes field, detection
// - Antenna off forces tag-present and info low
// - Type object selectable; supported types listed readable
// - Selected type code drives block size, count
// - Detected tag type readable at detail sub six
// - Type selection defaults to code two
// - Save request stores type in non-volatile memory
// - Info objects read zero while no tag
// - Strength zero without tag, else one to eight
// - Present asserts after switch-on depth successes
// - Depth zero no filter; each step one poll
// - Present clears after switch-off depth failures
// - Depth zero no filter; each step one poll
// - Mapped UID message sent on tag arrival, departure
// - UID also readable as two 32-bit words
// - Mapped data read and sent on new tag
// - Read data stored in wide entries one..sixty-four
// - Only mapped entries are read and refreshed
// - Entry reads its own start address and length
// - Narrow data object gives at most four bytes
// - Unused upper bits zero; one object per message
//////////////////////////////////////////////////////////////////////////////
package rftd_pkg;

    // Object indices
    localparam logic [15:0] OBJ_ANTENNA     = 16'h2151;
    localparam logic [15:0] OBJ_TYPE_SEL    = 16'h2161;
    localparam logic [15:0] OBJ_STRENGTH    = 16'h2162;
    localparam logic [15:0] OBJ_INFO_LIST   = 16'h2180;
    localparam logic [15:0] OBJ_INFO_DETAIL = 16'h2182;
    localparam logic [15:0] OBJ_UID_A       = 16'h2190;
    localparam logic [15:0] OBJ_UID_B       = 16'h2191;
    localparam logic [15:0] OBJ_RD_START    = 16'h2200;
    localparam logic [15:0] OBJ_RD_LEN      = 16'h2201;
    localparam logic [15:0] OBJ_RD_WIDE     = 16'h220a;
    localparam logic [15:0] OBJ_RD_NARROW   = 16'h220b;
    localparam logic [15:0] OBJ_ON_DEPTH    = 16'h4603;
    localparam logic [15:0] OBJ_OFF_DEPTH   = 16'h4605;

    // Sub-indices
    localparam logic [7:0] SUB_FIRST         = 8'h01;
    localparam logic [7:0] SUB_DETECTED_TYPE = 8'h06;
    localparam logic [7:0] SUB_INFO_LAST     = 8'hfe;
    localparam logic [7:0] SUB_LIST_UID      = 8'h01;

    // Values and reset values
    localparam logic [7:0] ANT_OFF       = 8'h00;
    localparam logic [7:0] ANT_ON        = 8'h01;
    localparam logic [7:0] RST_ANTENNA   = 8'h01;
    localparam logic [7:0] RST_TYPE_SEL  = 8'h02;
    localparam logic [7:0] RST_DEPTH     = 8'h00;
    localparam logic [7:0] TYPE_USER     = 8'h01;
    localparam logic [7:0] TYPE_LAST     = 8'h0d;
    localparam logic [3:0] STRENGTH_MAX  = 4'h8;
    localparam logic [3:0] WIDE_BYTES    = 4'h8;
    localparam logic [3:0] NARROW_BYTES  = 4'h4;

    // Poll timing
    localparam int CLK_HZ      = 100_000_000;
    localparam int POLL_MS     = 7;
    localparam int POLL_CYCLES = (CLK_HZ / 1000) * POLL_MS;

    // Object access request
    typedef struct packed {
        logic        wr;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [63:0] wdata;
    } rftd_od_req_s;

    // Front end poll result
    typedef struct packed {
        logic        found;
        logic [63:0] uid;
        logic [3:0]  strength;
        logic [7:0]  tag_type;
    } rftd_fe_res_s;

    // Transmit message carrier
    typedef struct packed {
        logic        is_uid;
        logic [7:0]  sub;
        logic [63:0] data;
    } rftd_pdo_s;

    // Block geometry of a tag type
    typedef struct packed {
        logic [5:0]  blk_bytes;
        logic [11:0] blk_count;
    } rftd_geom_s;

    function automatic rftd_geom_s rftd_geom(input logic [7:0] code);
        rftd_geom_s g;
        g = '0;
        unique case (code)
            8'h02:   g = '{6'h04, 12'h01c};
            8'h03:   g = '{6'h04, 12'h028};
            8'h04:   g = '{6'h04, 12'h008};
            8'h05:   g = '{6'h08, 12'h0fa};
            8'h06:   g = '{6'h04, 12'h03a};
            8'h07:   g = '{6'h20, 12'h100};
            8'h08:   g = '{6'h04, 12'h008};
            8'h09:   g = '{6'h04, 12'h040};
            8'h0a:   g = '{6'h04, 12'h020};
            8'h0b:   g = '{6'h04, 12'h040};
            8'h0c:   g = '{6'h04, 12'h800};
            8'h0d:   g = '{6'h04, 12'h04f};
            default: g = '0;
        endcase
        return g;
    endfunction

endpackage

// file: rftd_readout_sva.sv
// Port assertions for the tag detect readout
`timescale 1ns/1ps
module rftd_readout_sva (
    input logic mclk_i, nrst_i, od_valid_i, field_en_o, poll_o, fe_done_i,
    input logic tag_present_o, save_req_i, nv_save_o, rd_req_valid_o,
    input logic rd_req_ready_i, pdo_valid_o, pdo_ready_i,
    input logic [15:0] rd_addr_o,
    input rftd_pkg::rftd_od_req_s od_req_i,
    input rftd_pkg::rftd_fe_res_s fe_res_i,
    input rftd_pkg::rftd_pdo_s    pdo_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    logic aw;
    // Antenna object write in flight
    assign aw = od_valid_i && od_req_i.wr
              && od_req_i.index == rftd_pkg::OBJ_ANTENNA;
    chk_ant_off: assert property (aw && od_req_i.wdata == 0
        |-> ##[1:2] !field_en_o) else $error("field stays on");
    chk_ant_on: assert property (aw && od_req_i.wdata == 1
        |-> ##[1:2] field_en_o) else $error("field stays off");
    // Three cycles grace lets the clear land first
    chk_off_quiet: assert property (!field_en_o [*3]
        |-> !tag_present_o && !poll_o) else $error("active with field off");
    chk_rise_cause: assert property ($rose(tag_present_o)
        |-> $past(fe_done_i && fe_res_i.found)) else $error("rise uncaused");
    chk_pdo_hold: assert property (pdo_valid_o && !pdo_ready_i
        |=> pdo_valid_o && $stable(pdo_o)) else $error("message dropped");
    chk_rd_hold: assert property (rd_req_valid_o && !rd_req_ready_i
        |=> rd_req_valid_o && $stable(rd_addr_o)) else $error("read moved");
    chk_save_pulse: assert property (save_req_i |=> nv_save_o)
        else $error("no save pulse");
    chk_poll_gap: assert property (poll_o |=> !poll_o [*8])
        else $error("polls too close");
    cover property ($rose(tag_present_o));
    cover property ($fell(tag_present_o));
    cover property (pdo_valid_o && !pdo_ready_i);
endmodule
bind rftd_readout rftd_readout_sva u_chk (.*);

// file: rftd_fe_model.sv
// Front end and tag memory model facing the readout
`timescale 1ns/1ps
module rftd_fe_model (
    input  logic mclk_i, poll_o, rd_req_valid_o, slow_i, tag_i,
    input  logic [15:0] rd_addr_o,
    input  logic [63:0] uid,
    output logic fe_done_i, rd_req_ready_i, rd_done_i,
    output logic [63:0] rd_data_i,
    output rftd_pkg::rftd_fe_res_s fe_res_i
);
    logic t = 0;
    initial {fe_done_i, rd_req_ready_i, rd_done_i, rd_data_i, fe_res_i} = '0;
    // Answers follow each poll; idle lines scramble so stale data is seen
    always @(posedge mclk_i) begin
        t <= !t;
        fe_done_i <= poll_o;
        fe_res_i <= poll_o ? {tag_i, uid, 4'h9, 8'h05} : ~fe_res_i;
        rd_req_ready_i <= rd_req_valid_o && !rd_req_ready_i
                        && (t || !slow_i);
        rd_done_i <= rd_req_valid_o && rd_req_ready_i;
        rd_data_i <= rd_req_valid_o && rd_req_ready_i
                   ? {4{rd_addr_o}} : ~rd_data_i;
    end
endmodule

// file: rftd_readout_tb.sv
// Self-checking bench for the tag detect readout
`timescale 1ns/1ps
module rftd_readout_tb;
    logic mclk_i = 0, nrst_i = 0, od_valid_i = 0, tag_i = 0, slow_i = 0;
    logic uid_mapped_i = 1, save_req_i = 0, pdo_ready_i = 0, nv_load_i = 0;
    logic od_ack_o, od_err_o, fe_done_i, rd_req_ready_i, rd_done_i, nv_save_o;
    logic field_en_o, poll_o, tag_present_o, rd_req_valid_o, pdo_valid_o;
    logic [63:0] od_rdata_o, rd_data_i, uid, data_mapped_i = 1, d = 'h10_0010;
    logic [15:0] rd_addr_o;
    logic [3:0]  rd_len_o;
    logic [5:0]  blk_bytes_o;
    logic [11:0] blk_count_o;
    logic [7:0]  nv_type_o, nv_type_i = 0, tc[3] = '{5, 7, 12};
    logic [17:0] tg[3] = '{{6'h08, 12'h0fa}, {6'h20, 12'h100}, {6'h04, 12'h800}};
    rftd_pkg::rftd_od_req_s od_req_i = '0;
    rftd_pkg::rftd_fe_res_s fe_res_i;
    rftd_pkg::rftd_pdo_s    pdo_o, qp[$];
    logic [64:0] qo[$], err = 65'h1_0000_0000_0000_0000;
    int n_fail = 0, checks_done = 0, cyc = 0, n;
    rftd_readout #(.POLL_CYCLES(20)) dut (.*);
    rftd_fe_model fe (.*);
    initial forever #5 mclk_i = ~mclk_i;
    // Random receiver stalls and slow tag memory
    always @(negedge mclk_i) {pdo_ready_i, slow_i} = 2'($urandom);
    task automatic chk(string s, logic [72:0] e, logic [72:0] g);
        checks_done++;
        if (e !== g) begin
            n_fail++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic od(logic w, logic [15:0] i, logic [7:0] s,
                      logic [63:0] v, logic [64:0] e);
        od_req_i = '{w, i, s, v};
        od_valid_i = 1;
        qo.push_back(e);
        @(negedge mclk_i) od_valid_i = 0;
        @(negedge mclk_i);
    endtask
    // Counts poll results of the wanted kind until present settles
    task automatic count_to(logic v);
        n = 0;
        for (int i = 0; i < 300 && tag_present_o !== v; i++) begin
            @(negedge mclk_i);
            n += fe_done_i && fe_res_i.found === v;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Answer watcher pops the oldest note; cycle ceiling cuts hangs
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (od_ack_o === 1) chk("od", qo.pop_front(), {od_err_o, od_rdata_o});
        if (pdo_valid_o === 1 && pdo_ready_i === 1)
            chk("pdo", qp.pop_front(), pdo_o);
        if (cyc == 5000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'h8682));
        uid = {$urandom, $urandom};
        repeat (3) @(negedge mclk_i);
        nrst_i = 1;
        repeat (3) @(negedge mclk_i);
        od(0, rftd_pkg::OBJ_TYPE_SEL, 0, 0, 2);
        od(0, rftd_pkg::OBJ_STRENGTH, 0, 0, 0);
        od(1, rftd_pkg::OBJ_TYPE_SEL, 0, 14, err);
        od(1, rftd_pkg::OBJ_ANTENNA, 0, 2, err);
        for (int k = 0; k < 3; k++) begin
            od(1, rftd_pkg::OBJ_TYPE_SEL, 0, tc[k], 0);
            chk("geom", tg[k], {blk_bytes_o, blk_count_o});
        end
        save_req_i = 1;
        @(negedge mclk_i) save_req_i = 0;
        chk("nv type", 12, nv_type_o);
        $display("config test done");
        od(1, rftd_pkg::OBJ_RD_START, 1, 16'h10, 0);
        od(1, rftd_pkg::OBJ_RD_LEN, 1, 3, 0);
        od(1, rftd_pkg::OBJ_ON_DEPTH, 0, 2, 0);
        od(1, rftd_pkg::OBJ_OFF_DEPTH, 0, 1, 0);
        qp.push_back({1'b1, 8'h01, uid});
        qp.push_back({1'b0, 8'h01, d});
        tag_i = 1;
        count_to(1);
        chk("on polls", 3, n);
        repeat (60) @(negedge mclk_i);
        od(0, rftd_pkg::OBJ_INFO_LIST, 1, 0, uid);
        od(0, rftd_pkg::OBJ_STRENGTH, 0, 0, 8);
        od(0, rftd_pkg::OBJ_INFO_DETAIL, 6, 0, 5);
        od(0, rftd_pkg::OBJ_RD_WIDE, 2, 0, 0);
        od(0, rftd_pkg::OBJ_RD_NARROW, 1, 0, d);
        qp.push_back({1'b1, 8'h01, 64'h0});
        tag_i = 0;
        count_to(0);
        chk("off polls", 2, n);
        od(0, rftd_pkg::OBJ_INFO_LIST, 1, 0, 0);
        $display("detect test done");
        tag_i = 1;
        od(1, rftd_pkg::OBJ_ANTENNA, 0, 0, 0);
        repeat (80) @(negedge mclk_i);
        chk("ant off", 0, {field_en_o, tag_present_o});
        tag_i = 0;
        od(1, rftd_pkg::OBJ_ANTENNA, 0, 1, 0);
        chk("ant on", 1, field_en_o);
        repeat (60) @(negedge mclk_i);
        chk("queues", 0, qo.size() + qp.size());
        $display("antenna test done");
        end_sim();
    end
endmodule
